// >>> design/cct_pkg.sv
// cct_pkg: register map, field positions, reset values and counter constants for the capture/compare timer
// assumes a classic wishbone slave with 32-bit data, one register per aligned word
package cct_pkg;
  // byte offsets of the registers
  localparam logic [7:0] CTRL_ONE_ADDR   = 8'h00;
  localparam logic [7:0] CTRL_TWO_ADDR   = 8'h04;
  localparam logic [7:0] STATUS_ADDR     = 8'h08;
  localparam logic [7:0] CAPT_ONE_ADDR   = 8'h0C;
  localparam logic [7:0] CAPT_TWO_ADDR   = 8'h10;
  localparam logic [7:0] CMP_ONE_ADDR    = 8'h14;
  localparam logic [7:0] CMP_TWO_ADDR    = 8'h18;
  localparam logic [7:0] COUNT_ADDR      = 8'h1C;
  localparam logic [7:0] ALT_COUNT_ADDR  = 8'h20;
  localparam logic [7:0] LOWPWR_ADDR     = 8'h24;
  // control register one fields
  localparam int CAP_IRQ_EN_BIT   = 7;
  localparam int CMP_IRQ_EN_BIT   = 6;
  localparam int OVF_IRQ_EN_BIT   = 5;
  localparam int FORCE_TWO_BIT    = 4;
  localparam int FORCE_ONE_BIT    = 3;
  localparam int LEVEL_TWO_BIT    = 2;
  localparam int CAP_ONE_EDGE_BIT = 1;
  localparam int LEVEL_ONE_BIT    = 0;
  // control register two fields
  localparam int PIN_ONE_EN_BIT   = 7;
  localparam int PIN_TWO_EN_BIT   = 6;
  localparam int ONE_PULSE_BIT    = 5;
  localparam int PWM_BIT          = 4;
  localparam int CLK_SEL_HI_BIT   = 3;
  localparam int CLK_SEL_LO_BIT   = 2;
  localparam int CAP_TWO_EDGE_BIT = 1;
  localparam int EXT_EDGE_BIT     = 0;
  // status register fields
  localparam int CAP_ONE_FLAG_BIT = 7;
  localparam int CMP_ONE_FLAG_BIT = 6;
  localparam int OVF_FLAG_BIT     = 5;
  localparam int CAP_TWO_FLAG_BIT = 4;
  localparam int CMP_TWO_FLAG_BIT = 3;
  localparam int TIMER_OFF_BIT    = 2;
  // low-power register fields
  localparam int WAIT_BIT         = 0;
  localparam int HALT_BIT         = 1;
  localparam int GMASK_BIT        = 2;
  // reset values, one-pulse capture value and counter maximum
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam logic [15:0] COUNT_RESET     = 16'hFFFC;
  localparam logic [15:0] CMP_RESET       = 16'h8000;
  localparam logic [15:0] CAPT_OPM_VALUE  = 16'hFFFD;
  localparam logic [15:0] COUNT_MAX       = 16'hFFFF;
  // clock select codes
  localparam logic [1:0] CLK_DIV4 = 2'h0;
  localparam logic [1:0] CLK_DIV2 = 2'h1;
  localparam logic [1:0] CLK_DIV8 = 2'h2;
  localparam logic [1:0] CLK_EXT  = 2'h3;
  // prescaler terminal counts
  localparam logic [2:0] DIV2_LAST = 3'h1;
  localparam logic [2:0] DIV4_LAST = 3'h3;
  localparam logic [2:0] DIV8_LAST = 3'h7;
endpackage

// >>> design/cct_timer.sv
// cct_timer: 16-bit free-running capture/compare timer with one-pulse and pwm modes and low-power control
// assumes a classic wishbone master on SYS_CLK; pins arrive asynchronous and are synchronised here
// What this block does
// R1 - keeps running in wait, interrupt wakes cpu
// R2 - halt freezes counter; resumes held, reset restarts
// R3 - capture edge in halt arms, loads on wake
// R4 - per-group enables; pwm compare silent; halt unwakable
// R5 - one shared request, also gated by global mask
// R6 - capture enable gates both capture flags
// R7 - compare enable gates both compare flags
// R8 - overflow enable gates overflow flag
// R9 - force two copies level two to pin
// R10 - force one copies level one to pin
// R11 - level two on match two; pin one in modes
// R12 - capture one edge select: 0 fall, 1 rise
// R13 - level one to pin one on match one
// R14 - pin one enable only routes output
// R15 - pin two enable only routes output
// R16 - one-pulse: capture one edge starts pulse
// R17 - pwm: pulse from compare one, period compare two
// R18 - clock select divides by 4, 2, 8, external
// R19 - external select without pin stops counter
// R20 - three control/status, six sixteen-bit value registers
// R21 - control registers read/write, reset to zero
// R22 - capture two edge select: 0 fall, 1 rise
// R23 - external clock edge select: 0 fall, 1 rise
`timescale 1ns/1ps
module cct_timer #(
  parameter bit HAS_EXT_CLK = 1'b1
) (
  input  wire logic        SYS_CLK,
  input  wire logic        SRST,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [7:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  input  wire logic        CAPTURE_IN_PIN_ONE,
  input  wire logic        CAPTURE_IN_PIN_TWO,
  input  wire logic        EXT_TIMER_CLOCK_PIN,
  output logic             COMPARE_OUT_PIN_ONE,
  output logic             COMPARE_OUT_PIN_ONE_OE_N,
  output logic             COMPARE_OUT_PIN_TWO,
  output logic             COMPARE_OUT_PIN_TWO_OE_N,
  output logic             TIMER_IRQ,
  output logic             WAKE_FROM_WAIT
);
  logic [7:0]  ctrl_one;
  logic [7:0]  ctrl_two;
  logic [15:0] counter;
  logic [15:0] capt_one;
  logic [15:0] capt_two;
  logic [15:0] cmp_one;
  logic [15:0] cmp_two;
  logic [15:0] cmp_one_act;
  logic [15:0] cmp_two_act;
  logic        cap_one_flag;
  logic        cap_two_flag;
  logic        cmp_one_flag;
  logic        cmp_two_flag;
  logic        ovf_flag;
  logic        timer_off;
  logic        wait_mode;
  logic        halt_mode;
  logic        global_mask;
  logic        arm_one;
  logic        arm_two;
  logic        halt_d;
  logic        pin_one_lvl;
  logic        pin_two_lvl;
  logic [2:0]  presc;
  logic [2:0]  sync_c1;
  logic [2:0]  sync_c2;
  logic [2:0]  sync_ext;
  logic        stat_seen_cap1;
  logic        stat_seen_cap2;
  logic        stat_seen_cmp1;
  logic        stat_seen_cmp2;
  logic        stat_seen_ovf;

  // decoded mode and field views
  logic [1:0] clk_sel;
  logic       pwm_mode;
  logic       opm_mode;
  logic       wb_req;
  logic       wb_wr;
  logic       wb_rd;
  logic       wr_lo;
  logic       irq_req;
  assign clk_sel  = ctrl_two[cct_pkg::CLK_SEL_HI_BIT:cct_pkg::CLK_SEL_LO_BIT];
  assign pwm_mode = ctrl_two[cct_pkg::PWM_BIT];
  assign opm_mode = ctrl_two[cct_pkg::ONE_PULSE_BIT] & ~pwm_mode;
  assign wb_req   = CYC_I & STB_I & ~ACK_O;
  assign wb_wr    = wb_req & WE_I;
  assign wb_rd    = wb_req & ~WE_I;
  assign wr_lo    = wb_wr & SEL_I[0];

  // three-stage pin synchronisers; only stages two and three are compared
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      sync_c1  <= 3'h0;
      sync_c2  <= 3'h0;
      sync_ext <= 3'h0;
    end else begin
      sync_c1  <= {sync_c1[1:0], CAPTURE_IN_PIN_ONE};
      sync_c2  <= {sync_c2[1:0], CAPTURE_IN_PIN_TWO};
      sync_ext <= {sync_ext[1:0], EXT_TIMER_CLOCK_PIN};
    end
  end

  // accepted pin levels; a change counts once stages two and three agree
  logic [2:0] pin_lvl;
  logic [2:0] pin_new;
  logic [2:0] pin_agree;
  assign pin_new   = {sync_ext[2], sync_c2[2], sync_c1[2]};
  assign pin_agree = {sync_ext[1] == sync_ext[2], sync_c2[1] == sync_c2[2], sync_c1[1] == sync_c1[2]};
  always_ff @(posedge SYS_CLK) begin
    if (SRST)
      pin_lvl <= 3'h0;
    else
      pin_lvl <= (pin_agree & pin_new) | (~pin_agree & pin_lvl);
  end

  // edge detection with programmable polarity
  logic edge_c1;
  logic edge_c2;
  logic edge_ext;
  assign edge_c1  = pin_agree[0] & (pin_new[0] != pin_lvl[0]) &
                    (pin_new[0] == ctrl_one[cct_pkg::CAP_ONE_EDGE_BIT]);   // R12
  assign edge_c2  = pin_agree[1] & (pin_new[1] != pin_lvl[1]) &
                    (pin_new[1] == ctrl_two[cct_pkg::CAP_TWO_EDGE_BIT]);   // R22
  assign edge_ext = pin_agree[2] & (pin_new[2] != pin_lvl[2]) &
                    (pin_new[2] == ctrl_two[cct_pkg::EXT_EDGE_BIT]);       // R23

  // prescaler; frozen in halt and when the timer is disabled
  logic [2:0] presc_last;
  logic       tick;
  logic       running;
  assign running = ~halt_mode & ~timer_off;                                  // R1 R2
  always_comb begin
    unique case (clk_sel)                                                    // R18
      cct_pkg::CLK_DIV2: presc_last = cct_pkg::DIV2_LAST;
      cct_pkg::CLK_DIV8: presc_last = cct_pkg::DIV8_LAST;
      default:           presc_last = cct_pkg::DIV4_LAST;
    endcase
  end
  assign tick = running & ((clk_sel == cct_pkg::CLK_EXT) ? (edge_ext & HAS_EXT_CLK)   // R19
                                                         : (presc == presc_last));
  always_ff @(posedge SYS_CLK) begin
    if (SRST)
      presc <= 3'h0;
    else if (running)
      presc <= (presc >= presc_last) ? 3'h0 : presc + 3'h1;
  end

  // match and restart conditions
  logic match_one;
  logic match_two;
  logic cnt_wr;
  logic opm_trig;
  assign match_one = tick & (counter == cmp_one_act);
  assign match_two = tick & (counter == cmp_two_act);
  assign cnt_wr    = wr_lo & ((ADR_I == cct_pkg::COUNT_ADDR) | (ADR_I == cct_pkg::ALT_COUNT_ADDR));
  assign opm_trig  = opm_mode & edge_c1 & running;                           // R16

  // free-running counter; halt holds the count
  always_ff @(posedge SYS_CLK) begin
    if (SRST)
      counter <= cct_pkg::COUNT_RESET;                                       // R2
    else if (cnt_wr | opm_trig | (pwm_mode & match_two))                     // R17
      counter <= cct_pkg::COUNT_RESET;
    else if (tick)
      counter <= counter + 16'h0001;
  end

  // compare values; pwm takes new values only at period end
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      cmp_one     <= cct_pkg::CMP_RESET;
      cmp_two     <= cct_pkg::CMP_RESET;
      cmp_one_act <= cct_pkg::CMP_RESET;
      cmp_two_act <= cct_pkg::CMP_RESET;
    end else begin
      if (wb_wr & (ADR_I == cct_pkg::CMP_ONE_ADDR)) begin
        if (SEL_I[0]) cmp_one[7:0]  <= DAT_I[7:0];
        if (SEL_I[1]) cmp_one[15:8] <= DAT_I[15:8];
      end
      if (wb_wr & (ADR_I == cct_pkg::CMP_TWO_ADDR)) begin
        if (SEL_I[0]) cmp_two[7:0]  <= DAT_I[7:0];
        if (SEL_I[1]) cmp_two[15:8] <= DAT_I[15:8];
      end
      if (~pwm_mode | match_two) begin
        cmp_one_act <= cmp_one;
        cmp_two_act <= cmp_two;
      end
    end
  end

  // captures; halt arms, wake loads the held count
  logic halt_exit;
  assign halt_exit = halt_d & ~halt_mode;
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      capt_one <= 16'h0000;
      capt_two <= 16'h0000;
      arm_one  <= 1'b0;
      arm_two  <= 1'b0;
      halt_d   <= 1'b0;
    end else begin
      halt_d <= halt_mode;
      if (halt_mode & edge_c1 & ~pwm_mode & ~opm_mode) arm_one <= 1'b1;     // R3
      else if (halt_exit) arm_one <= 1'b0;
      if (halt_mode & edge_c2) arm_two <= 1'b1;                             // R3
      else if (halt_exit) arm_two <= 1'b0;
      if (opm_trig)
        capt_one <= cct_pkg::CAPT_OPM_VALUE;
      else if ((edge_c1 & ~halt_mode & ~pwm_mode & ~opm_mode) | (halt_exit & arm_one))
        capt_one <= counter;
      if ((edge_c2 & ~halt_mode) | (halt_exit & arm_two))
        capt_two <= counter;
    end
  end

  // flag set terms
  logic set_cap1;
  logic set_cap2;
  logic set_cmp1;
  logic set_cmp2;
  logic set_ovf;
  assign set_cap1 = (edge_c1 & ~halt_mode & ~pwm_mode) | (halt_exit & arm_one) | (pwm_mode & match_two);
  assign set_cap2 = (edge_c2 & ~halt_mode) | (halt_exit & arm_two);
  assign set_cmp1 = match_one & ~pwm_mode & ~opm_mode;                     // R4
  assign set_cmp2 = match_two & ~pwm_mode;                                   // R4
  assign set_ovf  = tick & (counter == cct_pkg::COUNT_MAX) & ~cnt_wr;

  // flag clear: status read arms, then low-byte access of the paired register clears
  logic stat_rd;
  logic acc_lo;
  assign stat_rd = wb_rd & (ADR_I == cct_pkg::STATUS_ADDR);
  assign acc_lo  = wb_req & SEL_I[0];
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      {cap_one_flag, cap_two_flag, cmp_one_flag, cmp_two_flag, ovf_flag} <= 5'h00;
      {stat_seen_cap1, stat_seen_cap2, stat_seen_cmp1, stat_seen_cmp2, stat_seen_ovf} <= 5'h00;
    end else begin
      if (stat_rd) begin
        stat_seen_cap1 <= cap_one_flag;
        stat_seen_cap2 <= cap_two_flag;
        stat_seen_cmp1 <= cmp_one_flag;
        stat_seen_cmp2 <= cmp_two_flag;
        stat_seen_ovf  <= ovf_flag;
      end
      // set wins over clear in the same cycle
      cap_one_flag <= set_cap1 | (cap_one_flag &
                      ~(stat_seen_cap1 & acc_lo & (ADR_I == cct_pkg::CAPT_ONE_ADDR)));
      cap_two_flag <= set_cap2 | (cap_two_flag &
                      ~(stat_seen_cap2 & acc_lo & (ADR_I == cct_pkg::CAPT_TWO_ADDR)));
      cmp_one_flag <= set_cmp1 | (cmp_one_flag &
                      ~(stat_seen_cmp1 & acc_lo & (ADR_I == cct_pkg::CMP_ONE_ADDR)));
      cmp_two_flag <= set_cmp2 | (cmp_two_flag &
                      ~(stat_seen_cmp2 & acc_lo & (ADR_I == cct_pkg::CMP_TWO_ADDR)));
      ovf_flag     <= set_ovf | (ovf_flag &
                      ~(stat_seen_ovf & acc_lo & (ADR_I == cct_pkg::COUNT_ADDR)));
    end
  end

  // control, disable and low-power registers
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      ctrl_one    <= cct_pkg::CTRL_RESET;                                    // R21
      ctrl_two    <= cct_pkg::CTRL_RESET;                                    // R21
      timer_off   <= 1'b0;
      wait_mode   <= 1'b0;
      halt_mode   <= 1'b0;
      global_mask <= 1'b1;
    end else begin
      if (wr_lo & (ADR_I == cct_pkg::CTRL_ONE_ADDR)) ctrl_one <= DAT_I[7:0];
      if (wr_lo & (ADR_I == cct_pkg::CTRL_TWO_ADDR)) ctrl_two <= DAT_I[7:0];
      if (wr_lo & (ADR_I == cct_pkg::STATUS_ADDR)) timer_off <= DAT_I[cct_pkg::TIMER_OFF_BIT];
      if (wr_lo & (ADR_I == cct_pkg::LOWPWR_ADDR)) begin
        wait_mode   <= DAT_I[cct_pkg::WAIT_BIT];
        halt_mode   <= DAT_I[cct_pkg::HALT_BIT];
        global_mask <= DAT_I[cct_pkg::GMASK_BIT];
      end else if (wait_mode & irq_req)
        wait_mode <= 1'b0;                                                   // R1
    end
  end

  // interrupt request: per-group enables, shared line, global mask
  assign irq_req = (ctrl_one[cct_pkg::CAP_IRQ_EN_BIT] & (cap_one_flag | cap_two_flag)) |   // R6
                   (ctrl_one[cct_pkg::CMP_IRQ_EN_BIT] & (cmp_one_flag | cmp_two_flag)) |   // R7
                   (ctrl_one[cct_pkg::OVF_IRQ_EN_BIT] & ovf_flag);                          // R8
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      TIMER_IRQ      <= 1'b0;
      WAKE_FROM_WAIT <= 1'b0;
    end else begin
      TIMER_IRQ      <= irq_req & ~global_mask;                                // R5
      WAKE_FROM_WAIT <= irq_req & wait_mode & ~halt_mode;                      // R1 R4
    end
  end

  // compare output levels
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      pin_one_lvl <= 1'b0;
      pin_two_lvl <= 1'b0;
    end else if (pwm_mode | opm_mode) begin
      if (opm_trig | (pwm_mode & match_two))
        pin_one_lvl <= ctrl_one[cct_pkg::LEVEL_TWO_BIT];                     // R11
      else if (match_one)
        pin_one_lvl <= ctrl_one[cct_pkg::LEVEL_ONE_BIT];                     // R13
    end else begin
      if (ctrl_one[cct_pkg::FORCE_ONE_BIT] | match_one)
        pin_one_lvl <= ctrl_one[cct_pkg::LEVEL_ONE_BIT];                     // R10 R13
      if (ctrl_one[cct_pkg::FORCE_TWO_BIT] | match_two)
        pin_two_lvl <= ctrl_one[cct_pkg::LEVEL_TWO_BIT];                     // R9 R11
    end
  end

  // pin routing: enables only route, matching runs regardless
  assign COMPARE_OUT_PIN_ONE      = pin_one_lvl;
  assign COMPARE_OUT_PIN_TWO      = pin_two_lvl;
  assign COMPARE_OUT_PIN_ONE_OE_N = ~(ctrl_two[cct_pkg::PIN_ONE_EN_BIT] & ~timer_off);   // R14
  assign COMPARE_OUT_PIN_TWO_OE_N = ~(ctrl_two[cct_pkg::PIN_TWO_EN_BIT] & ~timer_off & ~pwm_mode & ~opm_mode); // R15

  // wishbone read data and one-cycle ack; unmapped reads return zero
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h0000_0000;
    end else begin
      ACK_O <= wb_req;
      if (wb_rd) begin
        unique case (ADR_I)                                                  // R20
          cct_pkg::CTRL_ONE_ADDR:  DAT_O <= {24'h000000, ctrl_one};
          cct_pkg::CTRL_TWO_ADDR:  DAT_O <= {24'h000000, ctrl_two};
          cct_pkg::STATUS_ADDR:    DAT_O <= {24'h000000, cap_one_flag, cmp_one_flag, ovf_flag,
                                             cap_two_flag, cmp_two_flag, timer_off, 2'h0};
          cct_pkg::CAPT_ONE_ADDR:  DAT_O <= {16'h0000, capt_one};
          cct_pkg::CAPT_TWO_ADDR:  DAT_O <= {16'h0000, capt_two};
          cct_pkg::CMP_ONE_ADDR:   DAT_O <= {16'h0000, cmp_one};
          cct_pkg::CMP_TWO_ADDR:   DAT_O <= {16'h0000, cmp_two};
          cct_pkg::COUNT_ADDR:     DAT_O <= {16'h0000, counter};
          cct_pkg::ALT_COUNT_ADDR: DAT_O <= {16'h0000, counter};
          cct_pkg::LOWPWR_ADDR:    DAT_O <= {29'h0000000, global_mask, halt_mode, wait_mode};
          default:                 DAT_O <= 32'h0000_0000;
        endcase
      end
    end
  end

  // checks
  property p_reset_ctrl;
    @(posedge SYS_CLK) SRST |=> (ctrl_one == 8'h00 && ctrl_two == 8'h00 && counter == 16'hFFFC);
  endproperty
  a_reset_ctrl: assert property (p_reset_ctrl) else $error("control not cleared by reset"); // R21

  property p_halt_hold;
    @(posedge SYS_CLK) disable iff (SRST) (halt_mode && !cnt_wr && !opm_trig && !pwm_mode) |=> $stable(counter);
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("counter moved in halt"); // R2

  property p_irq_gate;
    @(posedge SYS_CLK) disable iff (SRST) (global_mask || !irq_req) |=> !TIMER_IRQ;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enable"); // R5

  property p_cap_en;
    @(posedge SYS_CLK) disable iff (SRST)
      (ctrl_one[7] && cap_one_flag && !global_mask) |=> TIMER_IRQ;
  endproperty
  a_cap_en: assert property (p_cap_en) else $error("capture irq missing"); // R6

  property p_pwm_no_cmp;
    @(posedge SYS_CLK) disable iff (SRST) (pwm_mode && !cmp_one_flag) |=> !cmp_one_flag;
  endproperty
  a_pwm_no_cmp: assert property (p_pwm_no_cmp) else $error("compare flag in pwm"); // R4

  property p_pin_one_en;
    @(posedge SYS_CLK) disable iff (SRST) !ctrl_two[7] |-> COMPARE_OUT_PIN_ONE_OE_N;
  endproperty
  a_pin_one_en: assert property (p_pin_one_en) else $error("pin one driven while disabled"); // R14

  property p_force_one;
    @(posedge SYS_CLK) disable iff (SRST)
      (ctrl_one[3] && !pwm_mode && !opm_mode) |=> (pin_one_lvl == $past(ctrl_one[0]));
  endproperty
  a_force_one: assert property (p_force_one) else $error("force one ignored"); // R10

  property p_ack;
    @(posedge SYS_CLK) disable iff (SRST) (CYC_I && STB_I && !ACK_O) |=> ACK_O ##1 !ACK_O;
  endproperty
  a_ack: assert property (p_ack) else $error("ack timing wrong"); // R20
endmodule

// >>> dv/cct_pin_partner.sv
// cct_pin_partner: circuitry on the capture, compare and external clock pins
// assumes SYS_CLK from the bench; pins change just after a rising edge
`timescale 1ns/1ps
module cct_pin_partner (
  input  wire logic SYS_CLK,
  input  wire logic cmp_one,
  input  wire logic cmp_one_oe_n,
  input  wire logic cmp_two,
  input  wire logic cmp_two_oe_n,
  output logic      cap_one,
  output logic      cap_two,
  output logic      ext_clk,
  output logic      wire_one,
  output logic      wire_two
);
  logic [1:0] ext_div;
  // pull-ups hold the compare wires high once the timer lets go
  assign wire_one = cmp_one_oe_n ? 1'b1 : cmp_one;
  assign wire_two = cmp_two_oe_n ? 1'b1 : cmp_two;
  // quiet pins at time zero
  initial begin
    cap_one = 1'b0;
    cap_two = 1'b0;
    ext_clk = 1'b0;
    ext_div = 2'h0;
  end
  // free-running external timer clock, eight system cycles a period
  always @(posedge SYS_CLK) begin
    ext_div <= ext_div + 2'h1;
    if (ext_div == 2'h3) begin
      ext_clk <= ~ext_clk;
    end
  end
  // capture pin levels, changed just after a rising edge
  task automatic drive_cap(input logic which, input logic lvl);
    @(posedge SYS_CLK);
    if (which) cap_two <= lvl;
    else cap_one <= lvl;
  endtask
endmodule

// >>> dv/cct_timer_tb.sv
// cct_timer_tb: self-checking bench for the capture/compare timer control
// assumes cct_pkg and cct_timer compiled first; reads are checked through a queue
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module cct_timer_tb;
  logic        sys_clk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hF;
  logic [31:0] dat_w = 32'h0, dat_r;
  logic [31:0] seed = 32'h00014FAC;
  logic [63:0] note;
  logic [63:0] exp_q[$];
  logic        ack, c1, c1n, c2, c2n, irq, cap1, cap2, ext, w1, w2, wk;
  logic [7:0]  ck_cfg[5] = '{8'h04, 8'h00, 8'h08, 8'h0D, 8'h0C};
  int          ck_exp[5] = '{32, 16, 8, 8, 8};
  int          err_total = 0, num_checks = 0, wake_seen = 0;

  // 250 MHz system clock
  always #2 sys_clk = ~sys_clk;

  cct_timer #(.HAS_EXT_CLK(1'b1)) u_cct_timer (.SYS_CLK(sys_clk), .SRST(srst), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack),
    .CAPTURE_IN_PIN_ONE(cap1), .CAPTURE_IN_PIN_TWO(cap2), .EXT_TIMER_CLOCK_PIN(ext),
    .COMPARE_OUT_PIN_ONE(c1), .COMPARE_OUT_PIN_ONE_OE_N(c1n), .COMPARE_OUT_PIN_TWO(c2),
    .COMPARE_OUT_PIN_TWO_OE_N(c2n), .TIMER_IRQ(irq), .WAKE_FROM_WAIT(wk));
  cct_pin_partner u_cct_pin_partner (.SYS_CLK(sys_clk), .cmp_one(c1), .cmp_one_oe_n(c1n), .cmp_two(c2),
    .cmp_two_oe_n(c2n), .cap_one(cap1), .cap_two(cap2), .ext_clk(ext), .wire_one(w1), .wire_two(w2));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // one classic cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    `CHK(ack, 1'b1)
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  // a zero mask notes the read without comparing it
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, output logic [31:0] q);
    exp_q.push_back({m, e});
    bus(1'b0, a, 32'h0, q);
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // takes the oldest note whenever read data is acknowledged
  always @(posedge sys_clk) begin
    if (ack === 1'b1 && cyc && !we && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      if (note[63:32] != 32'h0) `CHK(dat_r & note[63:32], note[31:0])
    end
  end

  // counts wake pulses out of wait
  always @(posedge sys_clk) begin
    if (wk === 1'b1) wake_seen++;
  end

  // watchdog cuts a hang short
  initial begin
    cycles(6000);
    err_total++;
    summarize();
  end

  // main sequence
  initial begin
    logic [31:0] q, q0, a;
    int          hi;
    cycles(4);
    srst <= 1'b0;
    rd(cct_pkg::CTRL_ONE_ADDR, 32'hFF, 32'h0, q);
    rd(cct_pkg::CTRL_TWO_ADDR, 32'hFF, 32'h0, q);
    rd(8'h40, 32'hFFFFFFFF, 32'h0, q);
    for (int i = 0; i < 4; i++) begin
      a = xs();
      wr(cct_pkg::CTRL_ONE_ADDR, {24'h0, a[7:0]});
      wr(cct_pkg::CTRL_TWO_ADDR, {24'h0, a[15:8]});
      rd(cct_pkg::CTRL_ONE_ADDR, 32'hFF, {24'h0, a[7:0]}, q);
      rd(cct_pkg::CTRL_TWO_ADDR, 32'hFF, {24'h0, a[15:8]}, q);
    end
    $display("done registers");
    wr(cct_pkg::CTRL_ONE_ADDR, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr(cct_pkg::CTRL_TWO_ADDR, {24'h0, ck_cfg[i]});
      wr(cct_pkg::COUNT_ADDR, 32'h0);
      cycles(64);
      rd(cct_pkg::COUNT_ADDR, 32'h0, 32'h0, q);
      a = {16'h0, q[15:0] - 16'hFFFC};
      `CHK(a >= ck_exp[i] - 1 && a <= ck_exp[i] + 3, 1'b1)
    end
    $display("done clock select");
    wr(cct_pkg::CTRL_TWO_ADDR, 32'h04);
    wr(cct_pkg::LOWPWR_ADDR, 32'h0);
    wr(cct_pkg::CTRL_ONE_ADDR, 32'h20);
    wr(cct_pkg::COUNT_ADDR, 32'h0);
    cycles(40);
    `CHK(irq, 1'b1)
    wr(cct_pkg::CTRL_ONE_ADDR, 32'h0);
    cycles(4);
    `CHK(irq, 1'b0)
    wr(cct_pkg::CTRL_ONE_ADDR, 32'h20);
    wr(cct_pkg::LOWPWR_ADDR, 32'h4);
    cycles(4);
    `CHK(irq, 1'b0)
    rd(cct_pkg::STATUS_ADDR, 32'h20, 32'h20, q);
    rd(cct_pkg::COUNT_ADDR, 32'h0, 32'h0, q);
    rd(cct_pkg::STATUS_ADDR, 32'h20, 32'h0, q);
    $display("done overflow");
    wr(cct_pkg::LOWPWR_ADDR, 32'h1);
    wr(cct_pkg::CTRL_ONE_ADDR, 32'h40);
    wr(cct_pkg::CMP_ONE_ADDR, 32'h0010);
    wr(cct_pkg::COUNT_ADDR, 32'h0);
    cycles(60);
    `CHK(irq, 1'b1)
    `CHK(wake_seen != 0, 1'b1)
    rd(cct_pkg::LOWPWR_ADDR, 32'h1, 32'h0, q);
    rd(cct_pkg::STATUS_ADDR, 32'h40, 32'h40, q);
    wr(cct_pkg::CTRL_ONE_ADDR, 32'h0);
    cycles(4);
    `CHK(irq, 1'b0)
    $display("done compare");
    wr(cct_pkg::CTRL_ONE_ADDR, 32'h80);
    u_cct_pin_partner.drive_cap(1'b0, 1'b1);
    cycles(12);
    `CHK(irq, 1'b0)
    u_cct_pin_partner.drive_cap(1'b0, 1'b0);
    cycles(12);
    `CHK(irq, 1'b1)
    rd(cct_pkg::STATUS_ADDR, 32'h80, 32'h80, q);
    wr(cct_pkg::CTRL_TWO_ADDR, 32'h06);
    u_cct_pin_partner.drive_cap(1'b1, 1'b1);
    cycles(12);
    rd(cct_pkg::STATUS_ADDR, 32'h10, 32'h10, q);
    $display("done capture");
    wr(cct_pkg::CTRL_TWO_ADDR, 32'hC4);
    wr(cct_pkg::CTRL_ONE_ADDR, 32'h1D);
    cycles(4);
    `CHK({c1n, c2n, w1, w2}, 4'h3)
    wr(cct_pkg::CTRL_ONE_ADDR, 32'h18);
    cycles(4);
    `CHK({w1, w2}, 2'h0)
    wr(cct_pkg::CTRL_TWO_ADDR, 32'h04);
    cycles(4);
    `CHK({c1n, c2n, w1, w2}, 4'hF)
    $display("done forced levels");
    wr(cct_pkg::CMP_ONE_ADDR, 32'h0040);
    wr(cct_pkg::CTRL_ONE_ADDR, 32'h06);
    wr(cct_pkg::CTRL_TWO_ADDR, 32'hA4);
    u_cct_pin_partner.drive_cap(1'b0, 1'b1);
    cycles(20);
    `CHK(w1, 1'b1)
    cycles(200);
    `CHK(w1, 1'b0)
    rd(cct_pkg::CAPT_ONE_ADDR, 32'hFFFF, 32'hFFFD, q);
    $display("done one pulse");
    // pwm: high from period end to compare one, period set by compare two
    wr(cct_pkg::CMP_ONE_ADDR, 32'h0008);
    wr(cct_pkg::CMP_TWO_ADDR, 32'h0010);
    wr(cct_pkg::CTRL_ONE_ADDR, 32'h04);
    wr(cct_pkg::CTRL_TWO_ADDR, 32'h94);
    wr(cct_pkg::COUNT_ADDR, 32'h0);
    cycles(90);
    hi = 0;
    repeat (84) begin
      @(posedge sys_clk);
      hi += w1;
    end
    `CHK(hi >= 50 && hi <= 54, 1'b1)
    rd(cct_pkg::STATUS_ADDR, 32'hC8, 32'h80, q);
    $display("done pwm");
    wr(cct_pkg::CTRL_TWO_ADDR, 32'h04);
    wr(cct_pkg::LOWPWR_ADDR, 32'h6);
    rd(cct_pkg::COUNT_ADDR, 32'h0, 32'h0, q0);
    cycles(30);
    rd(cct_pkg::COUNT_ADDR, 32'hFFFF, {16'h0, q0[15:0]}, q);
    @(posedge sys_clk);
    srst <= 1'b1;
    cycles(4);
    srst <= 1'b0;
    rd(cct_pkg::COUNT_ADDR, 32'h0, 32'h0, q);
    a = {16'h0, q[15:0] - 16'hFFFC};
    `CHK(a <= 4, 1'b1)
    rd(cct_pkg::CTRL_TWO_ADDR, 32'hFF, 32'h0, q);
    $display("done halt and reset");
    summarize();
  end
endmodule
